// ### cwd_config_decode.v
// configuration word store, decode and start-up reset hold
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "cwd_regs.vh"
module cwd_config_decode #(
  parameter POWERUP_DELAY_TIMER_CYCLES = `CWD_POWERUP_DELAY_TIMER_MS * 1000 * `CWD_CLK_MHZ
) (
  clk_sys,
  nrst,
  clk_wdt,
  porEvent,
  extResetReq,
  progMode,
  progAddr,
  progWrite,
  progWdata,
  progRdata,
  oscStable,
  osc_in_pin,
  haltReq,
  irqWake,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  code_protect,
  powerup_delay_enable_n,
  watchdog_enable_bit,
  osc_mode_select,
  extClockSel,
  coreReset,
  halted,
  wdtReset
);
  input  wire        clk_sys;
  input  wire        nrst;
  input  wire        clk_wdt;
  input  wire        porEvent;
  input  wire        extResetReq;
  input  wire        progMode;
  input  wire [13:0] progAddr;
  input  wire        progWrite;
  input  wire [13:0] progWdata;
  output reg  [13:0] progRdata;
  input  wire        oscStable;
  input  wire        osc_in_pin;
  input  wire        haltReq;
  input  wire        irqWake;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [11:0] paddr;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output wire        pready;
  output wire        pslverr;
  output reg         code_protect;
  output reg         powerup_delay_enable_n;
  output reg         watchdog_enable_bit;
  output reg  [1:0]  osc_mode_select;
  output wire        extClockSel;
  output wire        coreReset;
  output reg         halted;
  output wire        wdtReset;

  localparam [3:0] ST_CAPTURE = 4'b0001;
  localparam [3:0] ST_POWERUP_DELAY_TIMER    = 4'b0010;
  localparam [3:0] ST_OST     = 4'b0100;
  localparam [3:0] ST_RUN     = 4'b1000;
  localparam [31:0] POWERUP_DELAY_TIMER_N    = POWERUP_DELAY_TIMER_CYCLES;

  reg    [13:0]      cfgWord_r;
  reg    [3:0]       state_r;
  reg    [3:0]       state_nxt;
  reg    [31:0]      timer_r;
  reg                porSeen_r;
  reg                kick_r;
  reg                wdtS0_r;
  reg                wdtS1_r;
  reg                wdtS2_r;
  wire               wdtTimeout;
  wire               apbAcc;
  wire               isCrystal;
  wire               inTestSpace;
  wire               wdtTimeout_t;

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile word, programmer port

  assign inTestSpace = (progAddr >= `CWD_ADDR_TEST_LO)
                    && (progAddr <= `CWD_ADDR_TEST_HI);

  // erased cells are 1; programming can only clear bits
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfgWord_r <= `CWD_ERASED;
    end else if (progMode && progWrite
                 && progAddr == `CWD_ADDR_CFG_WORD) begin
      cfgWord_r <= cfgWord_r & progWdata;
    end
  end

  // reads of test space outside programming mode return nothing
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      progRdata <= 14'h0000;
    end else if (progMode && progAddr == `CWD_ADDR_CFG_WORD) begin
      progRdata <= cfgWord_r;
    end else if (progMode && inTestSpace) begin
      progRdata <= `CWD_ERASED;
    end else begin
      progRdata <= 14'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequence: capture, power-up delay, oscillator start-up

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_CAPTURE: begin
        if (porSeen_r && !cfgWord_r[`CWD_POWERUP_DELAY_ENABLE_N_BIT])
          state_nxt = ST_POWERUP_DELAY_TIMER;
        else
          state_nxt = ST_OST;
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (timer_r >= POWERUP_DELAY_TIMER_N - 32'h0000_0001)
          state_nxt = ST_OST;
      end
      ST_OST: begin
        if (!isCrystal || (oscStable
            && timer_r >= `CWD_OST_CYCLES - 1))
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (extResetReq || wdtTimeout)
          state_nxt = ST_CAPTURE;
      end
      default: state_nxt = ST_CAPTURE;
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r   <= ST_CAPTURE;
      timer_r   <= 32'h0000_0000;
      porSeen_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        timer_r <= 32'h0000_0000;
      else
        timer_r <= timer_r + 32'h0000_0001;
      // power-up delay only on the first pass after power-on
      if (porEvent)
        porSeen_r <= 1'b1;
      else if (state_r == ST_RUN)
        porSeen_r <= 1'b0;
    end
  end

  assign coreReset = (state_r != ST_RUN);

  // fields latched only while reset is held
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      code_protect           <= 1'b0;
      powerup_delay_enable_n <= 1'b1;
      watchdog_enable_bit    <= 1'b1;
      osc_mode_select        <= `CWD_OSC_RC;
    end else if (state_r == ST_CAPTURE) begin
      code_protect <= ~&cfgWord_r[`CWD_CP_HI:`CWD_CP_LO];
      powerup_delay_enable_n <= cfgWord_r[`CWD_POWERUP_DELAY_ENABLE_N_BIT];
      watchdog_enable_bit    <= cfgWord_r[`CWD_WATCHDOG_ENABLE_BIT_BIT];
      osc_mode_select <= cfgWord_r[`CWD_FOSC_HI:`CWD_FOSC_LO];
    end
  end

  // crystal modes take crystal or external clock alike on osc in
  assign isCrystal   = (osc_mode_select != `CWD_OSC_RC);
  assign extClockSel = isCrystal;

  ////////////////////////////////////////////////////////////////////////////
  // halt state and its wake-up sources

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      halted <= 1'b0;
    end else if (extResetReq || wdtTimeout || irqWake) begin
      halted <= 1'b0;
    end else if (haltReq && !coreReset) begin
      halted <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: enable comes only from the decoded word

  cwd_wdt u_wdt (
    .clk_wdt      (clk_wdt),
    .nrst         (nrst),
    .wdtEnable    (watchdog_enable_bit),
    .kickReq      (kick_r),
    .timeoutPulse (wdtTimeout_t)
  );

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wdtS0_r <= 1'b0;
      wdtS1_r <= 1'b0;
      wdtS2_r <= 1'b0;
    end else begin
      wdtS0_r <= wdtTimeout_t;
      wdtS1_r <= wdtS0_r;
      wdtS2_r <= wdtS1_r;
    end
  end
  assign wdtTimeout = wdtS1_r ^ wdtS2_r;
  assign wdtReset   = wdtTimeout;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: status view and watchdog kick only, word is read-only here

  assign apbAcc  = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = apbAcc && (paddr != `CWD_APB_CFG)
                && (paddr != `CWD_APB_STATUS)
                && (paddr != `CWD_APB_WDT_KICK);

  // software may only restart the count, never stop it
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      kick_r <= 1'b0;
    end else if (apbAcc && pwrite && paddr == `CWD_APB_WDT_KICK) begin
      kick_r <= ~kick_r;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CWD_APB_CFG:    prdata <= {18'h0_0000, cfgWord_r};
        `CWD_APB_STATUS: prdata <= {22'h00_0000, state_r, halted,
                                    code_protect, watchdog_enable_bit,
                                    powerup_delay_enable_n, osc_mode_select};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // cwd_config_decode

// ### cwd_config_decode_asserts.sv
// port assertions for the configuration decode block
`timescale 1ns/1ns
module cwd_config_decode_asserts #(
  parameter POWERUP_DELAY_TIMER_CYCLES = 20
) (
  input wire        clk_sys,
  input wire        nrst,
  input wire        progMode,
  input wire [13:0] progAddr,
  input wire [13:0] progRdata,
  input wire        oscStable,
  input wire        irqWake,
  input wire        extResetReq,
  input wire        code_protect,
  input wire        powerup_delay_enable_n,
  input wire        watchdog_enable_bit,
  input wire [1:0]  osc_mode_select,
  input wire        extClockSel,
  input wire        coreReset,
  input wire        halted,
  input wire        wdtReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////
  a_test_space: assert property (
    progMode && progAddr[13] && progAddr != 14'h2007
    |=> progRdata == 14'h3FFF) else $error("test space data wrong");
  a_user_blind: assert property (
    !progMode || !progAddr[13] |=> progRdata == 14'h0000)
    else $error("config space seen outside programming");
  a_fields_hold: assert property (
    !coreReset && $past(!coreReset) |-> $stable({code_protect,
    powerup_delay_enable_n, watchdog_enable_bit, osc_mode_select}))
    else $error("fields moved while running");
  a_xtal_sel: assert property (
    extClockSel == (osc_mode_select != 2'b11))
    else $error("crystal select wrong");
  // 16 cycles off covers the crossing into the rc domain and back
  logic [4:0] offCnt_r;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      offCnt_r <= 5'h00;
    else if (watchdog_enable_bit)
      offCnt_r <= 5'h00;
    else if (offCnt_r != 5'h10)
      offCnt_r <= offCnt_r + 5'h01;
  end
  a_wdt_off: assert property (
    offCnt_r == 5'h10 |-> !wdtReset)
    else $error("disabled watchdog fired");
  a_ext_reset: assert property (
    extResetReq |-> ##[1:4] coreReset) else $error("no reset hold");
  a_irq_wake: assert property (
    halted && irqWake |-> ##[1:4] !halted) else $error("no wake");
  a_osc_hold: assert property (
    $fell(coreReset) && extClockSel |-> $past(oscStable))
    else $error("released before oscillator stable");
  c_wake: cover property (halted ##1 !halted);
  c_xtal_run: cover property ($fell(coreReset) && extClockSel);
  c_wdt: cover property (wdtReset);
endmodule // cwd_config_decode_asserts
bind cwd_config_decode cwd_config_decode_asserts #(
  .POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) u_chk (.clk_sys, .nrst, .progMode,
  .progAddr, .progRdata, .oscStable, .irqWake, .extResetReq,
  .code_protect, .powerup_delay_enable_n, .watchdog_enable_bit,
  .osc_mode_select, .extClockSel, .coreReset, .halted, .wdtReset);

// ### cwd_prog_model.sv
// programmer model on the programming port
`timescale 1ns/1ns
module cwd_prog_model (
  input  wire        clk_sys,
  output reg         progMode  = 1'b0,
  output reg  [13:0] progAddr  = 14'h0000,
  output reg         progWrite = 1'b0,
  output reg  [13:0] progWdata = 14'h0000,
  input  wire [13:0] progRdata
);
  ////////////////////////////////////////////////
  // one access: reply taken once the registered answer has settled
  task xfer(input m, w, input [13:0] a, d, output [13:0] r);
    begin
      @(posedge clk_sys);
      progMode <= m;
      progAddr <= a;
      progWrite <= w;
      progWdata <= d;
      @(posedge clk_sys);
      progWrite <= 1'b0;
      @(posedge clk_sys);
      @(posedge clk_sys);
      r = progRdata;
      progMode <= 1'b0;
      // released lines invert, no stale copy
      progAddr <= ~a;
      progWdata <= ~d;
    end
  endtask
endmodule // cwd_prog_model

// ### cwd_regs.vh
// constants for the configuration word decode block
`ifndef CWD_REGS_VH
`define CWD_REGS_VH
`define CWD_ADDR_CFG_WORD   14'h2007
`define CWD_ADDR_TEST_LO    14'h2000
`define CWD_ADDR_TEST_HI    14'h3FFF
`define CWD_APB_CFG         12'h000
`define CWD_APB_STATUS      12'h004
`define CWD_APB_WDT_KICK    12'h008
`define CWD_WORD_W          14
`define CWD_ERASED          14'h3FFF
`define CWD_CP_HI           13
`define CWD_CP_LO           4
`define CWD_POWERUP_DELAY_ENABLE_N_BIT       3
`define CWD_WATCHDOG_ENABLE_BIT_BIT        2
`define CWD_FOSC_HI         1
`define CWD_FOSC_LO         0
`define CWD_OSC_RC          2'b11
`define CWD_OSC_HS          2'b10
`define CWD_OSC_XT          2'b01
`define CWD_OSC_LP          2'b00
`define CWD_POWERUP_DELAY_TIMER_MS         72
`define CWD_CLK_MHZ         100
`define CWD_OST_CYCLES      1024
`define CWD_WDT_TICKS       32'h0000_0800
`endif

// ### cwd_wdt.v
// watchdog counter running on its own rc oscillator clock
`timescale 1ns/1ns
module cwd_wdt (
  clk_wdt,
  nrst,
  wdtEnable,
  kickReq,
  timeoutPulse
);
`include "cwd_regs.vh"
  input  wire        clk_wdt;
  input  wire        nrst;
  input  wire        wdtEnable;
  input  wire        kickReq;
  output reg         timeoutPulse;

  reg    [31:0]      count_r;
  reg                kickS0_r;
  reg                kickS1_r;
  reg                kickS2_r;
  reg                enS0_r;
  reg                enS1_r;

  ////////////////////////////////////////////////////////////////////////////
  // kick is a toggle from the system domain
  always @(posedge clk_wdt or negedge nrst) begin
    if (!nrst) begin
      kickS0_r <= 1'b0;
      kickS1_r <= 1'b0;
      kickS2_r <= 1'b0;
      enS0_r   <= 1'b0;
      enS1_r   <= 1'b0;
    end else begin
      kickS0_r <= kickReq;
      kickS1_r <= kickS0_r;
      kickS2_r <= kickS1_r;
      enS0_r   <= wdtEnable;
      enS1_r   <= enS0_r;
    end
  end

  // independent clock so a stalled system clock still times out
  always @(posedge clk_wdt or negedge nrst) begin
    if (!nrst) begin
      count_r      <= 32'h0000_0000;
      timeoutPulse <= 1'b0;
    end else if (!enS1_r || (kickS1_r != kickS2_r)) begin
      // toggle kept: clearing it would look like a time-out downstream
      count_r      <= 32'h0000_0000;
    end else if (count_r == `CWD_WDT_TICKS) begin
      count_r      <= 32'h0000_0000;
      timeoutPulse <= ~timeoutPulse;
    end else begin
      count_r      <= count_r + 32'h0000_0001;
    end
  end
endmodule // cwd_wdt

// ### tb_top.sv
// testbench for the configuration decode block
`timescale 1ns/1ns
module tb_top;
  localparam int POWERUP_DELAY_TIMER = 40;
  logic clk_sys, nrst, clk_wdt, porEvent, extResetReq, progMode;
  logic progWrite, oscStable, osc_in_pin, haltReq, irqWake, psel;
  logic penable, pwrite, pready, pslverr, code_protect, halted;
  logic powerup_delay_enable_n, watchdog_enable_bit, extClockSel;
  logic coreReset, wdtReset;
  logic [13:0] progAddr, progWdata, progRdata;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  osc_mode_select;
  int          failures, totalChecks;
  cwd_config_decode #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER)) u_cwd_config_decode (.clk_sys,
    .nrst, .clk_wdt, .porEvent, .extResetReq, .progMode, .progAddr,
    .progWrite, .progWdata, .progRdata, .oscStable, .osc_in_pin,
    .haltReq, .irqWake, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .code_protect, .powerup_delay_enable_n,
    .watchdog_enable_bit, .osc_mode_select, .extClockSel, .coreReset,
    .halted, .wdtReset);
  cwd_prog_model u_cwd_prog_model (.clk_sys, .progMode, .progAddr,
    .progWrite, .progWdata, .progRdata);
  ////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // odd half-period keeps the rc clock unrelated in phase
  initial begin
    clk_wdt = 1'b0;
    #3;
    forever #19 clk_wdt = ~clk_wdt;
  end
  task chk(input [31:0] got, exp);
    begin
      totalChecks++;
      if (got !== exp) begin
        failures++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (failures == 0 && totalChecks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task do_reset;
    begin
      nrst <= 1'b0;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d,
           output [31:0] r, output e);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // sampled at the falling edge, where outputs are settled
  task wait_run(output int n);
    begin
      n = 0;
      @(negedge clk_sys);
      while (coreReset !== 1'b0 && n < 9000) begin
        @(negedge clk_sys);
        n++;
      end
      chk(coreReset, 1'b0);
      @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////////////
  task t_access;
    logic [13:0] r;
    logic [31:0] d;
    logic        e;
    begin
      u_cwd_prog_model.xfer(1, 0, 14'h2007, 14'h0000, r);
      chk(r, 14'h3FFF);
      u_cwd_prog_model.xfer(1, 0, 14'h2000, 14'h0000, r);
      chk(r, 14'h3FFF);
      u_cwd_prog_model.xfer(0, 1, 14'h2007, 14'h0000, r);
      chk(r, 14'h0000);
      apb(1, 12'h000, 32'h0000_0000, d, e);
      apb(0, 12'h000, 32'h0000_0000, d, e);
      chk(d, 32'h0000_3FFF);
      apb(0, 12'h00C, 32'h0000_0000, d, e);
      chk(e, 1'b1);
    end
  endtask
  task t_modes;
    logic [13:0] w [4];
    logic [13:0] r;
    logic [31:0] d;
    logic        e;
    logic        cp;
    int          n;
    begin
      w = '{14'h3FFF, 14'h3FF2, 14'h3FF5, 14'h0008};
      foreach (w[i]) begin
        do_reset;
        oscStable <= 1'b0;
        u_cwd_prog_model.xfer(1, 1, 14'h2007, w[i], r);
        chk(r, w[i]);
        extResetReq <= 1'b1;
        @(posedge clk_sys);
        extResetReq <= 1'b0;
        repeat (1100) @(posedge clk_sys);
        chk(coreReset, w[i][1:0] != 2'b11);
        oscStable <= 1'b1;
        wait_run(n);
        cp = w[i][13:4] != 10'h3FF;
        chk(code_protect, cp);
        chk(powerup_delay_enable_n, w[i][3]);
        chk(watchdog_enable_bit, w[i][2]);
        chk(osc_mode_select, w[i][1:0]);
        chk(extClockSel, w[i][1:0] != 2'b11);
        apb(0, 12'h004, 32'h0000_0000, d, e);
        chk(d[5:0], {1'b0, cp, w[i][2], w[i][3], w[i][1:0]});
      end
    end
  endtask
  task t_powerup_delay_timer;
    logic [13:0] r;
    int          n;
    begin
      do_reset;
      u_cwd_prog_model.xfer(1, 1, 14'h2007, 14'h3FF7, r);
      // power-on only arms the delay; the restart comes with it
      porEvent <= 1'b1;
      extResetReq <= 1'b1;
      @(posedge clk_sys);
      porEvent <= 1'b0;
      extResetReq <= 1'b0;
      wait_run(n);
      chk(n >= POWERUP_DELAY_TIMER && n < POWERUP_DELAY_TIMER + 8, 1'b1);
      extResetReq <= 1'b1;
      @(posedge clk_sys);
      extResetReq <= 1'b0;
      wait_run(n);
      chk(n < POWERUP_DELAY_TIMER - 4, 1'b1);
    end
  endtask
  // wake by interrupt, by external reset, then by watchdog
  task t_halt;
    int n;
    begin
      do_reset;
      wait_run(n);
      for (int s = 0; s < 3; s++) begin
        haltReq <= 1'b1;
        @(posedge clk_sys);
        haltReq <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(halted, 1'b1);
        irqWake <= (s == 0);
        extResetReq <= (s == 1);
        n = 0;
        while (halted !== 1'b0 && n < 12000) begin
          @(posedge clk_sys);
          n++;
        end
        irqWake <= 1'b0;
        extResetReq <= 1'b0;
        chk(n < (s == 2 ? 12000 : 6), 1'b1);
        wait_run(n);
      end
    end
  endtask
  // kicks spaced well inside the time-out must hold it off
  task t_kick;
    logic [31:0] d;
    logic        e;
    logic        seen;
    int          n;
    begin
      do_reset;
      wait_run(n);
      seen = 1'b0;
      repeat (6) begin
        repeat (1500) begin
          @(posedge clk_sys);
          seen = seen | wdtReset;
        end
        apb(1, 12'h008, 32'h0000_0000, d, e);
        chk(e, 1'b0);
      end
      chk(seen, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////
  initial begin
    {porEvent, extResetReq, oscStable, osc_in_pin} = 4'h0;
    {haltReq, irqWake, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    nrst = 1'b0;
    @(posedge clk_sys);
    do_reset;
    t_access;
    t_modes;
    t_powerup_delay_timer;
    t_halt;
    t_kick;
    final_report;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    final_report;
  end
endmodule // tb_top
